// ---- shared/modbus_consts.svh ----
`ifndef MODBUS_CONSTS_SVH
`define MODBUS_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ        50000000
`define GAP_MS        10
`define GAP_CYC       ((`GAP_MS * `CLK_HZ + 999) / 1000)
`define GAP_W         20

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DATA_MAX      202
`define FRAME_MAX     (`DATA_MAX + 4)
`define MIN_LEN       8'h04
`define FIX_LEN       9'h008
`define MULTI_HDR     9'h009
`define ADDR_BCAST    8'h00
`define ADDR_MAX      8'hfe

// ----------------------------------------------------------------
// check value
// ----------------------------------------------------------------
`define CRC_INIT      16'hffff
`define CRC_POLY      16'ha001

// ----------------------------------------------------------------
// function codes, limits, exceptions
// ----------------------------------------------------------------
`define FN_RD_OBITS   8'h01
`define FN_RD_BITS    8'h02
`define FN_RD_WORDS   8'h03
`define FN_WR_BIT     8'h05
`define FN_WR_WORD    8'h06
`define FN_WR_BITS    8'h0f
`define FN_WR_WORDS   8'h10
`define BIT_QTY_MAX   16'h0100
`define WORD_QTY_MAX  16'h0064
`define EXC_FLAG      8'h80
`define EXC_FUNC      8'h01
`define EXC_ADDR      8'h02
`define EXC_DATA      8'h03
`define EXC_FRAME     8'h07

`endif

// ---- shared/modbus_pkg.sv ----
package modbus_pkg;
`include "modbus_consts.svh"

  typedef logic [7:0] byte_t;

  typedef enum logic [5:0] {
    ST_RX    = 6'h01,
    ST_CHECK = 6'h02,
    ST_EXEC  = 6'h04,
    ST_LOAD  = 6'h08,
    ST_SEND  = 6'h10,
    ST_GAP   = 6'h20
  } fsm_t;

  typedef struct packed {
    fsm_t                           st;
    logic [7:0]                     cnt;
    logic [`GAP_W-1:0]              gap;
    logic [15:0]                    h1;
    logic [15:0]                    h2;
    logic [7:0]                     exc;
    logic [7:0]                     len;
    logic [7:0]                     idx;
    logic [7:0]                     rdIdx;
    logic [7:0]                     txd;
    logic                           bcast;
    logic                           cmdV;
    logic [`FRAME_MAX-1:0][7:0]     buffer;
  } framer_state_t;

  typedef struct packed {
    logic [15:0] crc;
  } crc_state_t;

endpackage : modbus_pkg

// ---- shared/crc_if.sv ----
`timescale 1ns/1ps
interface crc_if;
  logic        init;
  logic        fold;
  logic [7:0]  din;
  logic [15:0] crc;
  modport user   (output init, output fold, output din, input crc);
  modport engine (input init, input fold, input din, output crc);
endinterface : crc_if

// ---- rtl/modbus_crc16.sv ----
`timescale 1ns/1ps
`include "modbus_consts.svh"
module modbus_crc16 (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // engine side
  crc_if.engine     bus
);
  import modbus_pkg::*;

  crc_state_t q;
  crc_state_t d;

  // ----------------------------------------------------------------
  // one byte folded per call, eight shift steps
  // ----------------------------------------------------------------
  function automatic logic [15:0] foldByte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = {c[15:8], c[7:0] ^ b};
    for (int j = 0; j < 8; j++) begin
      if (r[0]) begin
        r = (r >> 1) ^ `CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : foldByte

  always_comb begin
    d = q;
    if (bus.init) begin
      d.crc = `CRC_INIT;
    end else if (bus.fold) begin
      d.crc = foldByte(q.crc, bus.din);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{crc: `CRC_INIT};
    end else begin
      q <= d;
    end
  end

  assign bus.crc = q.crc;

endmodule : modbus_crc16

// ---- rtl/modbus_rtu_slave_framer.sv ----
`timescale 1ns/1ps
`include "modbus_consts.svh"
module modbus_rtu_slave_framer #(
  parameter logic [`GAP_W-1:0] GAP_CYCLES = `GAP_W'(`GAP_CYC)
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  // configuration
  input  wire modbus_pkg::byte_t stationAddr,
  // receive byte stream
  input  wire logic            rxValid,
  input  wire modbus_pkg::byte_t rxByte,
  // transmit byte stream
  output logic                 txValid,
  output modbus_pkg::byte_t    txByte,
  input  wire logic            txReady,
  // request to application
  output logic                 cmdValid,
  output modbus_pkg::byte_t    cmdFunc,
  output logic [15:0]          cmdStart,
  output logic [15:0]          cmdQty,
  output logic                 cmdBcast,
  input  wire logic            cmdDone,
  input  wire modbus_pkg::byte_t cmdExc,
  // request payload read port
  input  wire modbus_pkg::byte_t payIdx,
  output modbus_pkg::byte_t    payByte,
  // reply data read port
  output modbus_pkg::byte_t    rdIdx,
  input  wire modbus_pkg::byte_t rdByte,
  // status
  output logic                 busy
);
  import modbus_pkg::*;

  localparam framer_state_t RST = '{st: ST_RX, default: '0};

  framer_state_t q;
  framer_state_t d;
  crc_if         crcBus ();
  logic          crcInit;
  logic          crcFold;
  logic [7:0]    crcDin;

  modbus_crc16 u_crc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .bus     (crcBus.engine)
  );

  assign crcBus.init = crcInit;
  assign crcBus.fold = crcFold;
  assign crcBus.din  = crcDin;

  // ----------------------------------------------------------------
  // request decode, read straight from the frame buffer
  // ----------------------------------------------------------------
  logic [7:0]  fn;
  logic [15:0] qty;
  logic [7:0]  bcnt;
  logic [15:0] rxCrc;
  logic [7:0]  cntM1;
  logic [7:0]  cntM2;
  logic        isBitRd;
  logic        isWordRd;
  logic        isSingle;
  logic        isBitWr;
  logic        isWordWr;
  logic        isRead;
  logic        supported;
  logic [8:0]  expLen;
  logic [7:0]  bitBytes;
  logic        qtyOk;
  logic        countOk;
  logic        stationOk;
  logic        addrHit;
  logic        addrBcast;
  logic [7:0]  checkExc;
  logic [7:0]  okLen;
  logic [7:0]  txSel;
  logic [7:0]  lastCov;

  assign fn        = q.buffer[1];
  assign qty       = {q.buffer[4], q.buffer[5]};
  assign bcnt      = q.buffer[6];
  assign cntM1     = q.cnt - 8'h01;
  assign cntM2     = q.cnt - 8'h02;
  assign rxCrc     = {q.buffer[cntM1], q.buffer[cntM2]};
  assign isBitRd   = (fn == `FN_RD_OBITS) || (fn == `FN_RD_BITS);
  assign isWordRd  = (fn == `FN_RD_WORDS);
  assign isSingle  = (fn == `FN_WR_BIT) || (fn == `FN_WR_WORD);
  assign isBitWr   = (fn == `FN_WR_BITS);
  assign isWordWr  = (fn == `FN_WR_WORDS);
  assign isRead    = isBitRd || isWordRd;
  assign supported = isRead || isSingle || isBitWr || isWordWr;
  assign expLen    = (isBitWr || isWordWr) ?
                     (`MULTI_HDR + {1'b0, bcnt}) : `FIX_LEN;
  assign bitBytes  = 8'((qty + 16'h0007) >> 3);

  // quantity must be nonzero and within the per-function ceiling
  always_comb begin
    qtyOk = 1'b1;
    if (isBitRd || isBitWr) begin
      qtyOk = (qty != 16'h0000) && (qty <= `BIT_QTY_MAX);
    end else if (isWordRd || isWordWr) begin
      qtyOk = (qty != 16'h0000) && (qty <= `WORD_QTY_MAX);
    end
  end

  assign countOk   = isBitWr  ? (bcnt == bitBytes) :
                     isWordWr ? (bcnt == 8'({qty[6:0], 1'b0})) : 1'b1;
  assign stationOk = (stationAddr != `ADDR_BCAST) &&
                     (stationAddr <= `ADDR_MAX);
  assign addrBcast = (q.buffer[0] == `ADDR_BCAST);
  assign addrHit   = stationOk && (q.buffer[0] == stationAddr);

  // framing faults first, then function, then length, then values
  always_comb begin
    if ((q.cnt < `MIN_LEN) || (q.cnt > 8'(`FRAME_MAX))) begin
      checkExc = `EXC_FRAME;
    end else if (rxCrc != q.h2) begin
      checkExc = `EXC_FRAME;
    end else if (!supported) begin
      checkExc = `EXC_FUNC;
    end else if ({1'b0, q.cnt} != expLen) begin
      checkExc = `EXC_FRAME;
    end else if (!qtyOk || !countOk) begin
      checkExc = `EXC_DATA;
    end else begin
      checkExc = 8'h00;
    end
  end

  assign okLen = isBitRd  ? (bitBytes + 8'h01) :
                 isWordRd ? (8'({qty[6:0], 1'b0}) + 8'h01) : 8'h04;

  // ----------------------------------------------------------------
  // reply byte selection
  // ----------------------------------------------------------------
  assign lastCov = q.len + 8'h01;

  always_comb begin
    if (q.idx == 8'h00) begin
      txSel = q.buffer[0];
    end else if (q.idx == 8'h01) begin
      txSel = (q.exc != 8'h00) ? (fn | `EXC_FLAG) : fn;
    end else if (q.idx <= lastCov) begin
      if (q.exc != 8'h00) begin
        txSel = q.exc;
      end else if (isRead) begin
        txSel = (q.idx == 8'h02) ? (q.len - 8'h01) : rdByte;
      end else begin
        txSel = q.buffer[q.idx];
      end
    end else if (q.idx == q.len + 8'h02) begin
      txSel = crcBus.crc[7:0];
    end else begin
      txSel = crcBus.crc[15:8];
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.cmdV  = 1'b0;
    crcInit = 1'b0;
    crcFold = 1'b0;
    crcDin  = rxByte;
    case (q.st)
      ST_RX: begin
        if (rxValid) begin
          if (q.cnt < 8'(`FRAME_MAX)) begin
            d.buffer[q.cnt] = rxByte;
          end
          if (q.cnt != 8'hff) begin
            d.cnt = q.cnt + 8'h01;
          end
          d.h2    = q.h1;
          d.h1    = crcBus.crc;
          crcFold = 1'b1;
          d.gap   = '0;
        end else if (q.cnt != 8'h00) begin
          if (q.gap == GAP_CYCLES) begin
            d.st = ST_CHECK;
          end else begin
            d.gap = q.gap + 1'b1;
          end
        end
      end
      ST_CHECK: begin
        d.idx   = 8'h00;
        d.rdIdx = 8'h00;
        d.bcast = addrBcast;
        if (!addrHit && !addrBcast) begin
          d       = RST;
          crcInit = 1'b1;
        end else if (checkExc != 8'h00) begin
          if (addrBcast) begin
            d       = RST;
          end else begin
            d.exc = checkExc;
            d.len = 8'h01;
            d.st  = ST_LOAD;
          end
          crcInit = 1'b1;
        end else begin
          d.cmdV = 1'b1;
          d.st   = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cmdDone) begin
          crcInit = 1'b1;
          if (q.bcast) begin
            d = RST;
          end else begin
            d.exc = cmdExc;
            d.len = (cmdExc != 8'h00) ? 8'h01 : okLen;
            d.st  = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        d.txd = txSel;
        d.st  = ST_SEND;
      end
      ST_SEND: begin
        if (txReady) begin
          if (q.idx <= lastCov) begin
            crcFold = 1'b1;
            crcDin  = q.txd;
          end
          if (isRead && (q.exc == 8'h00) && (q.idx >= 8'h03) &&
              (q.idx <= lastCov)) begin
            d.rdIdx = q.rdIdx + 8'h01;
          end
          if (q.idx == q.len + 8'h03) begin
            d.st  = ST_GAP;
            d.gap = '0;
          end else begin
            d.idx = q.idx + 8'h01;
            d.st  = ST_LOAD;
          end
        end
      end
      ST_GAP: begin
        if (q.gap == GAP_CYCLES) begin
          d       = RST;
          crcInit = 1'b1;
        end else begin
          d.gap = q.gap + 1'b1;
        end
      end
      default: begin
        d       = RST;
        crcInit = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign txValid  = (q.st == ST_SEND);
  assign txByte   = q.txd;
  assign cmdValid = q.cmdV;
  assign cmdFunc  = fn;
  assign cmdStart = {q.buffer[2], q.buffer[3]};
  assign cmdQty   = isSingle ? 16'h0001 : qty;
  assign cmdBcast = q.bcast;
  assign rdIdx    = q.rdIdx;
  // payload port indexes the raw frame; out-of-range reads return zero
  assign payByte  = (payIdx < 8'(`FRAME_MAX)) ? q.buffer[payIdx] : 8'h00;
  assign busy     = (q.st != ST_RX);

endmodule : modbus_rtu_slave_framer

// ---- testbench/modbus_rtu_slave_framer_properties.sv ----
`timescale 1ns/1ps
module framer_checker #(
  parameter logic [19:0] GAP_CYCLES = 20'h7a120
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rstn,
  // streams
  input wire logic              rxValid,
  input wire logic              txValid,
  input wire modbus_pkg::byte_t txByte,
  input wire logic              txReady,
  // request side
  input wire logic              cmdValid,
  input wire modbus_pkg::byte_t cmdFunc,
  input wire logic [15:0]       cmdQty,
  input wire logic              cmdBcast,
  input wire modbus_pkg::byte_t rdIdx,
  input wire logic              busy
);
  import modbus_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // idle counter since the last received byte
  // ----------------------------------------------------------------
  int idleQ;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) idleQ <= 0;
    else if (rxValid) idleQ <= 0;
    else if (idleQ < 1000000) idleQ <= idleQ + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_GAP: assert property ($rose(busy) |-> idleQ >= GAP_CYCLES)
    else $error("frame closed before the idle gap");
  AST_RX_QUIET: assert property (rxValid && !busy |=> !busy [*8])
    else $error("frame closed right after a byte");
  AST_TX_HOLD: assert property (txValid && !txReady |=>
    txValid && $stable(txByte))
    else $error("tx byte dropped or changed while stalled");
  AST_TX_BUSY: assert property (txValid |-> busy)
    else $error("tx while receiving");
  AST_CMD_PULSE: assert property (cmdValid |=> !cmdValid)
    else $error("request pulse too long");
  AST_FUNC: assert property (cmdValid |-> cmdFunc inside {8'h01, 8'h02,
    8'h03, 8'h05, 8'h06, 8'h0f, 8'h10})
    else $error("unsupported code passed on");
  AST_QTY_WORD: assert property (cmdValid && cmdFunc inside {8'h03, 8'h10}
    |-> cmdQty inside {[16'h0001:16'h0064]})
    else $error("word quantity out of range");
  AST_QTY_BIT: assert property (cmdValid && cmdFunc inside {8'h01, 8'h02,
    8'h0f} |-> cmdQty inside {[16'h0001:16'h0100]})
    else $error("bit quantity out of range");
  AST_BCAST: assert property (cmdValid && cmdBcast |=> !txValid [*8])
    else $error("reply to broadcast");
  AST_RDIDX: assert property (!$stable(rdIdx) |->
    rdIdx == $past(rdIdx) + 8'h01 || rdIdx == 8'h00)
    else $error("reply data index skipped");
endmodule : framer_checker

bind modbus_rtu_slave_framer framer_checker #(.GAP_CYCLES(GAP_CYCLES)) chk (
  .ref_clk(ref_clk), .rstn(rstn), .rxValid(rxValid), .txValid(txValid),
  .txByte(txByte), .txReady(txReady), .cmdValid(cmdValid),
  .cmdFunc(cmdFunc), .cmdQty(cmdQty), .cmdBcast(cmdBcast),
  .rdIdx(rdIdx), .busy(busy));

// ---- testbench/modbus_master_model.sv ----
`timescale 1ns/1ps
module modbus_master_model (
  // clock
  input  wire logic              ref_clk,
  // frame stream to the slave
  output logic                   rxValid,
  output modbus_pkg::byte_t      rxByte,
  // reply stream from the slave
  input  wire logic              txValid,
  input  wire modbus_pkg::byte_t txByte,
  output logic                   txReady,
  input  wire logic              slow
);
  import modbus_pkg::*;
  byte_t got[$];
  int    seed = 61762;
  initial begin
    rxValid = 1'b0;
    rxByte  = 8'h00;
    txReady = 1'b0;
  end
  // bytes go back to back; the caller leaves the gap after them
  task automatic send(input byte_t f[$]);
    foreach (f[i]) begin
      @(posedge ref_clk);
      rxValid <= 1'b1;
      rxByte  <= f[i];
    end
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxByte  <= ~rxByte; // idle line must not show a stale byte
  endtask : send
  always @(posedge ref_clk) begin
    if (txValid && txReady) got.push_back(txByte);
    txReady <= !slow || ($random(seed) & 1);
  end
endmodule : modbus_master_model

// ---- testbench/modbus_rtu_slave_framer_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module modbus_rtu_slave_framer_tb_top;
  import modbus_pkg::*;
  typedef byte_t q_t[$];
  logic        ref_clk, rstn, rxValid, txValid, txReady, cmdValid;
  logic        cmdBcast, cmdDone, busy, slow, expB;
  byte_t       stationAddr, rxByte, txByte, cmdFunc, cmdExc, appExc;
  byte_t       payIdx, payByte, rdIdx, rdByte, expF, expP;
  logic [15:0] cmdStart, cmdQty, expS, expQ;
  int          bad_count, n_compared, nCmd, nExp, seed = 61762;
  assign rdByte = rdIdx ^ 8'h5a;
  modbus_rtu_slave_framer #(.GAP_CYCLES(20'h00014)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .stationAddr(stationAddr),
    .rxValid(rxValid), .rxByte(rxByte), .txValid(txValid),
    .txByte(txByte), .txReady(txReady), .cmdValid(cmdValid),
    .cmdFunc(cmdFunc), .cmdStart(cmdStart), .cmdQty(cmdQty),
    .cmdBcast(cmdBcast), .cmdDone(cmdDone), .cmdExc(cmdExc),
    .payIdx(payIdx), .payByte(payByte), .rdIdx(rdIdx), .rdByte(rdByte),
    .busy(busy));
  modbus_master_model mst (.ref_clk(ref_clk), .rxValid(rxValid),
    .rxByte(rxByte), .txValid(txValid), .txByte(txByte),
    .txReady(txReady), .slow(slow));
  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16(q_t f, int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, f[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16
  function automatic q_t fr(q_t f);
    logic [15:0] c;
    c = crc16(f, f.size());
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    return f;
  endfunction : fr
  function automatic q_t model(q_t f, byte_t ae);
    q_t    r;
    int    n, q, e, k;
    byte_t fn;
    n = f.size();
    if (f[0] != 8'h00 && (f[0] != stationAddr || f[0] == 8'hff))
      return r;
    fn = f[1];
    q = {f[4], f[5]};
    k = (fn == 8'h0f || fn == 8'h10) ? 9 + f[6] : 8;
    e = 0;
    if (n < 4 || n > 206) e = 7;
    else if (crc16(f, n - 2) != {f[n - 1], f[n - 2]}) e = 7;
    else if (!(fn inside {1, 2, 3, 5, 6, 15, 16})) e = 1;
    else if (n != k) e = 7;
    else if (fn inside {1, 2, 15} && (q == 0 || q > 256)) e = 3;
    else if (fn inside {3, 16} && (q == 0 || q > 100)) e = 3;
    else if (fn == 8'h0f && f[6] != (q + 7) / 8) e = 3;
    else if (fn == 8'h10 && f[6] != 2 * q) e = 3;
    else begin
      nExp++;
      e = ae;
    end
    if (f[0] == 8'h00) return r;
    r.push_back(f[0]);
    if (e != 0) begin
      r.push_back(fn | 8'h80);
      r.push_back(byte_t'(e));
    end else begin
      r.push_back(fn);
      if (fn <= 8'h03) begin
        k = (fn == 8'h03) ? 2 * q : (q + 7) / 8;
        r.push_back(byte_t'(k));
        for (int i = 0; i < k; i++) r.push_back(byte_t'(i) ^ 8'h5a);
      end else for (int i = 2; i < 6; i++) r.push_back(f[i]);
    end
    return fr(r);
  endfunction : model
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic waitBusy(logic v, int lim);
    int t;
    t = 0;
    while (busy !== v) begin
      @(negedge ref_clk);
      t++;
      if (t > lim) begin
        bad_count++;
        $display("ERROR %0t timeout", $time);
        end_sim();
      end
    end
  endtask : waitBusy
  task automatic setSt(byte_t a);
    @(posedge ref_clk);
    stationAddr <= a;
    @(posedge ref_clk);
  endtask : setSt
  // the master leaves the full idle gap: busy rises only after it
  task automatic xfer(q_t f, byte_t ae);
    q_t ex;
    nExp = 0;
    nCmd = 0;
    appExc = ae;
    expB = (f[0] == 8'h00);
    expF = f[1];
    expP = f[payIdx];
    expS = {f[2], f[3]};
    expQ = (f[1] inside {8'h05, 8'h06}) ? 16'h0001 : {f[4], f[5]};
    ex = model(f, ae);
    mst.got.delete();
    mst.send(f);
    waitBusy(1'b1, 100);
    waitBusy(1'b0, 6000);
    `CHK(mst.got.size(), ex.size())
    foreach (ex[i]) `CHK(mst.got[i], ex[i])
    `CHK(nCmd, nExp)
  endtask : xfer
  // application side answers each request one cycle later
  always @(posedge ref_clk) begin
    cmdDone <= cmdValid;
    cmdExc  <= cmdValid ? appExc : 8'h00;
    if (cmdValid) nCmd++;
    if (cmdValid) `CHK(cmdBcast, expB)
    if (cmdValid) `CHK(cmdFunc, expF)
    if (cmdValid) `CHK(cmdQty, expQ)
    if (cmdValid) `CHK(cmdStart, expS)
    if (cmdValid) `CHK(payByte, expP)
  end
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    q_t    f;
    byte_t a;
    int    q, r;
    rstn = 1'b0;
    stationAddr = 8'h01;
    payIdx = 8'h04;
    slow = 1'b0;
    appExc = 8'h00;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02, 8'hc4, 8'h0b}, 0);
    xfer('{8'h01, 8'h06, 8'h00, 8'h00, 8'h01, 8'h00, 8'h88, 8'h5a}, 0);
    slow <= 1'b1;
    xfer(fr('{8'h01, 8'h01, 8'h00, 8'h10, 8'h01, 8'h00}), 0);
    xfer(fr('{8'h01, 8'h01, 8'h00, 8'h10, 8'h01, 8'h01}), 0);
    xfer(fr('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h09}), 0);
    xfer(fr('{8'h01, 8'h05, 8'h00, 8'h03, 8'hff, 8'h00}), 0);
    xfer(fr('{8'h01, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h08, 8'h01,
              8'ha5}), 0);
    xfer(fr('{8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02,
              8'h12, 8'h34}), 0);
    xfer(fr('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h64}), 0);
    xfer(fr('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h65}), 0);
    xfer(fr('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h07}), 0);
    xfer(fr('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}), 0);
    xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02, 8'hc4, 8'h0c}, 0);
    xfer(fr('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}), 0);
    xfer('{8'h01, 8'h03, 8'h00}, 0);
    xfer(fr('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}), 8'h02);
    f = '{8'h01, 8'h10};
    repeat (203) f.push_back(8'h00);
    xfer(fr(f), 0);
    setSt(8'hff);
    xfer(fr('{8'hff, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}), 0);
    for (int i = 0; i < 6; i++) begin
      a = byte_t'(1 + $unsigned($random(seed)) % 254);
      q = 1 + $unsigned($random(seed)) % 100;
      r = $random(seed);
      setSt(a);
      slow <= i[0];
      xfer(fr('{a, 8'h03, byte_t'(r >> 8), byte_t'(r), 8'h00,
                byte_t'(q)}), 0);
    end
    end_sim();
  end
endmodule : modbus_rtu_slave_framer_tb_top
